// ===== spi_port.sv
// Purpose: pin side of a serial port acting as master or slave on 1, 2 or 4 lanes
// Assumes: master clock made here by a divider; slave logic clocked by the external clock
// Notes: dual and quad lanes are half duplex, direction chosen per word
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - clock pin output as master, input as slave
// - lanes two and three only in quad
// - open-drain option: pull low or release only
// - dual/quad: both primary lanes share direction
// - ready driven as slave, master waits on it
// - master asserts only addressed slave select
// - master reports foreign select as error
module spi_port
  import spi_pins_pkg::*;
#(
  parameter int SEL_N = SEL_COUNT
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk_in,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic [LANES-1:0] dat_i,
  output lane_pins_t dat_pins,
  input wire logic rdy_i,
  output logic rdy_o,
  output logic rdy_oe,
  output logic [SEL_N-1:0] slave_select_out_n,
  input wire logic sel_in_n,
  input wire logic master_en,
  input wire lane_mode_t lane_mode,
  input wire logic open_drain_option,
  input wire logic ready_en,
  input wire logic fault_detect_en,
  input wire logic fault_clear,
  input wire logic [$clog2(SEL_N)-1:0] slave_index,
  input wire logic [7:0] half_period,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire xfer_req_t tx_req,
  output logic rx_valid,
  output logic [WORD_W-1:0] rx_data,
  input wire logic slave_ready,
  input wire xfer_req_t slave_tx,
  output logic slave_rx_valid,
  output logic [WORD_W-1:0] slave_rx_data,
  output logic mode_fault
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_SHIFT = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    logic [7:0] div_cnt;
    logic sclk;
    logic last;
    logic [2:0] beat;
    logic [WORD_W-1:0] shift;
    logic rx_dir;
    logic fault;
    logic rx_valid;
    logic [WORD_W-1:0] rx_data;
    logic [1:0] sel_sync;
    logic [1:0] rdy_sync;
    logic [LANES-1:0] din_s0;
    logic [LANES-1:0] din_s1;
    logic [2:0] tog_sync;
    logic tog_last;
    logic srx_valid;
    logic [WORD_W-1:0] srx_data;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;
  logic sel_active;
  logic rdy_ok;
  logic half_done;
  logic [LANES-1:0] m_samp;
  logic [LANES-1:0] m_bits;
  logic [LANES-1:0] lane_bits;
  logic [LANES-1:0] lane_en;
  logic link_tog;
  logic [WORD_W-1:0] link_rx;
  logic [LANES-1:0] link_din;
  logic [LANES-1:0] link_dout;
  logic [8:0] div_next;

  // lane code 3 decodes as single, like the package helpers
  function automatic logic single_lane(input lane_mode_t mode);
    single_lane = (mode != LANE_DUAL) && (mode != LANE_QUAD);
  endfunction

  assign sel_active = ~st_r.sel_sync[1];
  assign rdy_ok = ~ready_en | st_r.rdy_sync[1];
  assign div_next = {1'b0, st_r.div_cnt} + 9'h001;
  // below two cycles a half, synced lanes would lag a whole beat
  assign half_done = div_next >= {1'b0, (half_period < MIN_HALF_PERIOD) ? MIN_HALF_PERIOD : half_period};
  // single lane: master listens on lane 1, otherwise on the active lanes
  assign m_samp = single_lane(lane_mode) ? {3'h0, st_r.din_s1[1]} : st_r.din_s1;

  // slave shifter on the external clock; single lane listens on lane 0
  assign link_din = single_lane(lane_mode) ? {3'h0, dat_i[0]} : dat_i;
  spi_link_slave u_link (
    .link_clk(sclk_in),
    .frame_idle(sel_in_n),
    .lane_mode(lane_mode),
    .tx_data(slave_tx.data),
    .din(link_din),
    .dout(link_dout),
    .rx_word(link_rx),
    .word_tog(link_tog)
  );

  // master word engine, synchronisers and slave word pickup
  always_comb begin
    st_nxt = st_r;
    st_nxt.sel_sync = {st_r.sel_sync[0], sel_in_n};
    st_nxt.rdy_sync = {st_r.rdy_sync[0], rdy_i};
    st_nxt.din_s0 = dat_i;
    st_nxt.din_s1 = st_r.din_s0;
    st_nxt.tog_sync = {st_r.tog_sync[1:0], link_tog};
    st_nxt.rx_valid = 1'b0;
    st_nxt.srx_valid = 1'b0;
    // foreign master seen on the select input; set beats clear
    if (fault_clear) begin
      st_nxt.fault = 1'b0;
    end
    if (master_en && fault_detect_en && sel_active) begin
      st_nxt.fault = 1'b1;
    end
    unique case (st_r.fsm)
      ST_IDLE: begin
        st_nxt.sclk = 1'b0;
        if (tx_valid && tx_ready) begin
          st_nxt.shift = tx_req.data;
          st_nxt.rx_dir = tx_req.rx_dir;
          st_nxt.beat = BEAT_RESET;
          st_nxt.last = 1'b0;
          st_nxt.div_cnt = '0;
          st_nxt.fsm = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // no clock edge while the slave says not ready
        if (rdy_ok) begin
          st_nxt.fsm = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        st_nxt.div_cnt = div_next[7:0];
        if (half_done) begin
          st_nxt.div_cnt = '0;
          st_nxt.sclk = ~st_r.sclk;
          if (!st_r.sclk) begin
            st_nxt.shift = shift_in(st_r.shift, m_samp, lane_mode);
            st_nxt.beat = st_r.beat + 3'h1;
            if (st_r.beat == last_beat(lane_mode)) begin
              st_nxt.last = 1'b1;
              st_nxt.rx_valid = 1'b1;
              st_nxt.rx_data = st_nxt.shift;
            end
          end else if (st_r.last) begin
            st_nxt.fsm = ST_IDLE;
          end
        end
      end
      default: st_nxt.fsm = ST_IDLE;
    endcase
    // a fault or a mode change drops the word and parks the clock low
    if (st_r.fault || !master_en) begin
      st_nxt.fsm = ST_IDLE;
      st_nxt.sclk = 1'b0;
    end
    // third toggle stage keeps the word event behind the select sync
    st_nxt.tog_last = st_r.tog_sync[2];
    if (!sel_active) begin
      st_nxt.tog_last = 1'b0;
    end else if (!master_en && (st_r.tog_sync[2] != st_r.tog_last)) begin
      st_nxt.srx_valid = 1'b1;
      st_nxt.srx_data = link_rx;
    end
  end

  // synchronous active-low reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= '{fsm: ST_IDLE, div_cnt: 8'h00, beat: BEAT_RESET, shift: WORD_RESET,
                rx_data: WORD_RESET, srx_data: WORD_RESET, sel_sync: 2'h3, rdy_sync: 2'h0,
                din_s0: 4'h0, din_s1: 4'h0, tog_sync: 3'h0, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // lane drive: which lanes the port owns this cycle
  assign m_bits = lane_out(st_r.shift, lane_mode);
  always_comb begin
    lane_bits = '0;
    lane_en = '0;
    if (master_en && st_r.fsm != ST_IDLE) begin
      if (single_lane(lane_mode)) begin
        lane_bits = {3'h0, m_bits[0]};
        lane_en = 4'h1;
      end else if (!st_r.rx_dir) begin
        lane_bits = m_bits;
        lane_en = (lane_mode == LANE_QUAD) ? 4'hf : 4'h3;
      end
    end else if (!master_en && sel_active) begin
      if (single_lane(lane_mode)) begin
        lane_bits = {2'h0, link_dout[0], 1'b0};
        lane_en = 4'h2;
      end else if (!slave_tx.rx_dir) begin
        lane_bits = link_dout;
        lane_en = (lane_mode == LANE_QUAD) ? 4'hf : 4'h3;
      end
    end
  end

  // open-drain lanes only pull low or let go
  always_comb begin
    dat_pins = '0;
    for (int k = 0; k < LANES; k++) begin
      {dat_pins.o[k], dat_pins.oe[k]} = lane_drive(lane_bits[k], lane_en[k], open_drain_option);
    end
  end

  assign sclk_o = st_r.sclk;
  assign sclk_oe = master_en;
  assign rdy_o = slave_ready;
  assign rdy_oe = ~master_en & ready_en;
  // only the addressed select goes low while a word is under way
  always_comb begin
    slave_select_out_n = '1;
    if (master_en && st_r.fsm != ST_IDLE) begin
      slave_select_out_n[slave_index] = 1'b0;
    end
  end
  assign tx_ready = master_en & ~st_r.fault & (st_r.fsm == ST_IDLE);
  assign rx_valid = st_r.rx_valid;
  assign rx_data = st_r.rx_data;
  assign slave_rx_valid = st_r.srx_valid;
  assign slave_rx_data = st_r.srx_data;
  assign mode_fault = st_r.fault;

  property p_clk_dir;
    @(posedge core_clk) disable iff (!rst_b) !master_en |=> master_en || (!sclk_oe && !sclk_o);
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin driven as slave");
  property p_upper_lanes;
    @(posedge core_clk) disable iff (!rst_b) lane_mode != LANE_QUAD |-> dat_pins.oe[3:2] == 2'h0;
  endproperty
  a_upper_lanes: assert property (p_upper_lanes) else $error("lane two or three used outside quad");
  property p_open_drain;
    @(posedge core_clk) disable iff (!rst_b) open_drain_option |-> (dat_pins.o & dat_pins.oe) == 4'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("lane driven high in open-drain");
  property p_pair_dir;
    @(posedge core_clk) disable iff (!rst_b)
      !single_lane(lane_mode) && !open_drain_option |-> dat_pins.oe[0] == dat_pins.oe[1];
  endproperty
  a_pair_dir: assert property (p_pair_dir) else $error("primary lanes differ in direction");
  property p_ready_hold;
    @(posedge core_clk) disable iff (!rst_b)
      (st_r.fsm == ST_HOLD && ready_en && !st_r.rdy_sync[1] && master_en) |=> st_r.fsm != ST_SHIFT && !sclk_o;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("master clocked while slave not ready");
  property p_sel_one;
    @(posedge core_clk) disable iff (!rst_b)
      $rose(sclk_o) |-> $onehot(~slave_select_out_n) && !slave_select_out_n[slave_index];
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("wrong slave select during clock");
  property p_fault_set;
    @(posedge core_clk) disable iff (!rst_b)
      (master_en && fault_detect_en && sel_active) |=> mode_fault ##1 (tx_ready == 1'b0);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("foreign select not reported");
  property p_single_lanes;
    @(posedge core_clk) disable iff (!rst_b) single_lane(lane_mode) && !open_drain_option |->
      dat_pins.oe == ((master_en && st_r.fsm != ST_IDLE) ? 4'h1 : (!master_en && sel_active) ? 4'h2 : 4'h0);
  endproperty
  a_single_lanes: assert property (p_single_lanes) else $error("single lane direction wrong");
  property p_slave_quiet;
    @(posedge core_clk) disable iff (!rst_b) (!master_en && !sel_active) |-> dat_pins.oe == 4'h0 && !slave_rx_valid;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave active without select");

  c_master_word: cover property (@(posedge core_clk) disable iff (!rst_b) rx_valid ##[1:600] tx_ready);
  c_ready_wait: cover property (@(posedge core_clk) disable iff (!rst_b) st_r.fsm == ST_HOLD [*4] ##1 st_r.fsm == ST_SHIFT);
  c_fault: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(mode_fault));
  c_slave_word: cover property (@(posedge core_clk) disable iff (!rst_b) slave_rx_valid);

endmodule
`default_nettype wire

// ===== spi_pins_pkg.sv
// Purpose: shared constants, types and lane helpers for the serial port pin logic
// Assumes: word width fixed at eight bits; lanes 0..3 are out, in, lane two, lane three
// Notes: lane k of a beat carries shift bit (WORD_W - lanes + k)
package spi_pins_pkg;

  localparam int WORD_W = 8;
  localparam int LANES = 4;
  localparam int SEL_COUNT = 4;
  localparam logic [7:0] HALF_PERIOD_RESET = 8'h04;
  // shortest master half period; the lane synchroniser eats two cycles
  localparam logic [7:0] MIN_HALF_PERIOD = 8'h02;
  localparam logic [2:0] BEAT_RESET = 3'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;

  // lane usage; not a state machine, so plain binary codes
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL = 2'h1,
    LANE_QUAD = 2'h2
  } lane_mode_t;

  // one transfer request: payload plus direction for dual and quad lanes
  typedef struct packed {
    logic rx_dir;
    logic [WORD_W-1:0] data;
  } xfer_req_t;

  // one group of lane pins seen from the port
  typedef struct packed {
    logic [LANES-1:0] o;
    logic [LANES-1:0] oe;
  } lane_pins_t;

  // index of the last beat of a word
  function automatic logic [2:0] last_beat(input lane_mode_t mode);
    unique case (mode)
      LANE_DUAL: last_beat = 3'h3;
      LANE_QUAD: last_beat = 3'h1;
      default: last_beat = 3'h7;
    endcase
  endfunction

  // bits presented on the lanes for the current beat
  function automatic logic [LANES-1:0] lane_out(input logic [WORD_W-1:0] sh, input lane_mode_t mode);
    unique case (mode)
      LANE_DUAL: lane_out = {2'h0, sh[WORD_W-1 -: 2]};
      LANE_QUAD: lane_out = sh[WORD_W-1 -: 4];
      default: lane_out = {3'h0, sh[WORD_W-1]};
    endcase
  endfunction

  // shift one beat in; single lane takes its bit from din[0]
  function automatic logic [WORD_W-1:0] shift_in(input logic [WORD_W-1:0] sh, input logic [LANES-1:0] din,
                                                 input lane_mode_t mode);
    unique case (mode)
      LANE_DUAL: shift_in = {sh[WORD_W-3:0], din[1:0]};
      LANE_QUAD: shift_in = {sh[WORD_W-5:0], din[3:0]};
      default: shift_in = {sh[WORD_W-2:0], din[0]};
    endcase
  endfunction

  // push-pull or open-drain drive of one lane, returns {o, oe}
  function automatic logic [1:0] lane_drive(input logic bit_v, input logic en, input logic od);
    lane_drive = od ? {1'b0, en & ~bit_v} : {bit_v, en};
  endfunction

endpackage

// ===== spi_link_slave.sv
// Purpose: slave shifter running on the serial clock driven by the external master
// Assumes: lane_mode, rx_dir and tx_data stay still while the frame is open
// Notes: cleared by the frame's own select going idle, as the clock stops between frames
`timescale 1ns/1ps
`default_nettype none
module spi_link_slave
  import spi_pins_pkg::*;
(
  input wire logic link_clk,
  input wire logic frame_idle,
  input wire lane_mode_t lane_mode,
  input wire logic [WORD_W-1:0] tx_data,
  input wire logic [LANES-1:0] din,
  output logic [LANES-1:0] dout,
  output logic [WORD_W-1:0] rx_word,
  output logic word_tog
);

  typedef struct packed {
    logic started;
    logic [2:0] beat;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] rx_word;
    logic tog;
  } link_state_t;

  link_state_t ls_r;
  link_state_t ls_nxt;
  logic [WORD_W-1:0] cur_word;

  // the first beat of each word comes straight from the held transmit word
  assign cur_word = ls_r.started ? ls_r.shift : tx_data;
  assign dout = lane_out(cur_word, lane_mode);
  assign rx_word = ls_r.rx_word;
  assign word_tog = ls_r.tog;

  // capture on the rising edge; next bits appear right after it
  always_comb begin
    ls_nxt = ls_r;
    ls_nxt.shift = shift_in(cur_word, din, lane_mode);
    ls_nxt.started = 1'b1;
    ls_nxt.beat = ls_r.beat + 3'h1;
    if (ls_r.beat == last_beat(lane_mode)) begin
      ls_nxt.rx_word = ls_nxt.shift;
      ls_nxt.tog = ~ls_r.tog; // word event toward the core clock
      ls_nxt.started = 1'b0;
      ls_nxt.beat = BEAT_RESET;
    end
  end

  // asynchronous clear by the idle select; constants only
  always_ff @(posedge link_clk or posedge frame_idle) begin
    if (frame_idle) begin
      ls_r <= '0;
    end else begin
      ls_r <= ls_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== spi_far_dev.sv
// Purpose: far-side peripheral model for the port in master role
// Assumes: lanes carry pull-ups, so a released lane reads high
// Notes: slow mode drops ready for 400 ns after each frame
`timescale 1ns/1ps
`default_nettype none
module spi_far_dev
  import spi_pins_pkg::*;
(
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic [LANES-1:0] lanes,
  input wire lane_mode_t mode,
  input wire logic rx_dir,
  input wire logic [WORD_W-1:0] reply,
  input wire logic slow,
  output logic [LANES-1:0] m_o,
  output logic [LANES-1:0] m_oe,
  output logic m_rdy,
  output logic [WORD_W-1:0] got
);
  logic [WORD_W-1:0] sh = 8'h00;
  logic [LANES-1:0] lanes_d;
  int n;
  assign n = (mode == LANE_QUAD) ? 4 : (mode == LANE_DUAL) ? 2 : 1;
  // 1 ns hold copy, so a lane changed on the clock's own edge is not seen early
  always @(lanes) lanes_d <= #1 lanes;
  // drive only while selected; wide lanes only while the master reads
  always_comb begin
    m_oe = 4'h0;
    m_o = 4'(sh[7:4] >> (4 - n));
    if (!sel_n && n == 1) begin
      m_oe = 4'h2;
      m_o = {2'h0, sh[7], 1'b0};
    end else if (!sel_n && rx_dir) begin
      m_oe = 4'((1 << n) - 1);
    end
  end
  // load at select, capture and advance on each rising edge; one process owns the shifter
  initial got = 8'h00;
  always @(negedge sel_n or posedge sclk) begin
    if (!sel_n && !sclk) begin
      sh = reply;
    end else if (!sel_n) begin
      got = 8'(got << n) | {4'h0, lanes_d & 4'((1 << n) - 1)};
      sh = 8'(sh << n);
    end
  end
  // a slow device needs time after each frame
  initial m_rdy = 1'b1;
  always @(posedge sel_n) begin
    if (slow) begin
      m_rdy = 1'b0;
      #400 m_rdy = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== spi_port_tb.sv
// Purpose: self-checking bench for the port pins as master and as slave
// Assumes: pull-ups on lanes; 80 ns link clock runs inside frames, plus one closing burst with no select
// Notes: expected bytes come from bench stimulus and exp_q, never from the design
`timescale 1ns/1ps
`default_nettype none
module spi_port_tb;
  import spi_pins_pkg::*;
  logic core_clk, rst_b, tb_sclk, sel_in_n, master_en, open_drain_option, ready_en, fault_detect_en;
  logic fault_clear, tx_valid, slave_ready, slow, sclk_o, sclk_oe, rdy_o, rdy_oe, tx_ready, rx_valid;
  logic slave_rx_valid, mode_fault, m_rdy;
  logic [1:0] slave_index;
  logic [3:0] tb_o, tb_oe, m_o, m_oe, slave_select_out_n;
  logic [7:0] half_period, rx_data, slave_rx_data, reply, got;
  logic [31:0] seed;
  lane_mode_t lane_mode;
  xfer_req_t tx_req, slave_tx;
  lane_pins_t dat_pins;
  wire logic [3:0] lane_w;
  wire logic sclk_w, rdy_w;
  int fails, n_compared;
  logic [7:0] exp_q[$], srx_q[$];
  // wire levels: design first, then far side, then bench, else pull-up
  assign sclk_w = sclk_oe ? sclk_o : tb_sclk;
  assign rdy_w = rdy_oe ? rdy_o : m_rdy;
  assign lane_w = (dat_pins.oe & dat_pins.o) | (~dat_pins.oe & m_oe & m_o)
    | (~dat_pins.oe & ~m_oe & ~(tb_oe & ~tb_o));
  spi_port #(.SEL_N(4)) dut (.core_clk, .rst_b, .sclk_in(sclk_w), .sclk_o, .sclk_oe, .dat_i(lane_w), .dat_pins,
    .rdy_i(rdy_w), .rdy_o, .rdy_oe, .slave_select_out_n, .sel_in_n, .master_en, .lane_mode, .open_drain_option,
    .ready_en, .fault_detect_en, .fault_clear, .slave_index, .half_period, .tx_valid, .tx_ready, .tx_req,
    .rx_valid, .rx_data, .slave_ready, .slave_tx, .slave_rx_valid, .slave_rx_data, .mode_fault);
  spi_far_dev far (.sclk(sclk_w), .sel_n(slave_select_out_n[slave_index]), .lanes(lane_w), .mode(lane_mode),
    .rx_dir(tx_req.rx_dir), .reply, .slow, .m_o, .m_oe, .m_rdy, .got);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cmp1(input logic act, input logic exp);
    cmp8({7'h0, act}, {7'h0, exp});
  endtask
  task automatic hang();
    fails++;
    end_of_test();
  endtask
  // pin rules, read before the edge's own updates land
  always @(posedge core_clk) begin
    if (rst_b === 1'b1) begin
      cmp1(sclk_oe, master_en);
      cmp1(rdy_oe, !master_en && ready_en);
      if (!master_en) cmp1(rdy_o, slave_ready);
      if (open_drain_option) cmp8({4'h0, dat_pins.o & dat_pins.oe}, 8'h00);
      if (lane_mode != LANE_QUAD) cmp8({6'h0, dat_pins.oe[3:2]}, 8'h00);
      if (lane_mode == LANE_DUAL || lane_mode == LANE_QUAD) begin
        if (!open_drain_option) cmp1(dat_pins.oe[1], dat_pins.oe[0]);
      end else begin
        cmp1(dat_pins.oe[master_en], 1'b0);
      end
      cmp1(slave_select_out_n === 4'hf || slave_select_out_n === ~(4'h1 << slave_index), 1'b1);
    end
    if (slave_rx_valid === 1'b1) srx_q.push_back(slave_rx_data);
  end
  // one master word; hold cycles of idle clock are demanded while ready is low
  task automatic mword(input logic dir, input int hold);
    int i;
    logic wide;
    seed = lfsr(seed);
    wide = lane_mode == LANE_DUAL || lane_mode == LANE_QUAD;
    @(negedge core_clk);
    tx_req = '{rx_dir: dir, data: seed[7:0]};
    reply = seed[15:8];
    exp_q.push_back(seed[15:8]);
    tx_valid = 1'b1;
    for (i = 0; tx_ready !== 1'b1; i++) begin
      if (i > 400) hang();
      @(negedge core_clk);
    end
    @(negedge core_clk);
    tx_valid = 1'b0;
    repeat (hold) begin
      @(negedge core_clk);
      cmp1(sclk_o, 1'b0);
    end
    for (i = 0; rx_valid !== 1'b1; i++) begin
      if (i > 4000) hang();
      @(negedge core_clk);
    end
    if (!wide || dir) cmp8(rx_data, exp_q[0]);
    if (!wide || !dir) cmp8(got, tx_req.data);
    exp_q.delete();
    // settings may only move once the last half period is over
    for (i = 0; tx_ready !== 1'b1; i++) begin
      if (i > 400) hang();
      @(negedge core_clk);
    end
  endtask
  // one slave frame clocked by the bench as external master
  task automatic sword(input logic dir);
    logic [7:0] tx, seen;
    logic [3:0] mk;
    int n, b;
    seed = lfsr(seed);
    n = lane_mode == LANE_QUAD ? 4 : lane_mode == LANE_DUAL ? 2 : 1;
    mk = 4'((1 << n) - 1);
    tx = seed[7:0];
    seen = 8'h00;
    srx_q.delete();
    @(negedge core_clk);
    slave_tx = '{rx_dir: dir, data: seed[15:8]};
    slave_ready = seed[16];
    sel_in_n = 1'b0;
    tb_oe = (n > 1 && !dir) ? 4'h0 : mk;
    #97;
    for (b = 0; b < 8; b += n) begin
      tb_o = 4'(8'(tx << b) >> (8 - n));
      #40;
      seen = 8'(seen << n) | {4'h0, (n == 1) ? {3'h0, lane_w[1]} : (lane_w & mk)};
      tb_sclk = 1'b1;
      #40;
      tb_sclk = 1'b0;
    end
    #80;
    @(negedge core_clk);
    sel_in_n = 1'b1;
    tb_oe = 4'h0;
    #60;
    cmp8(8'(srx_q.size()), 8'h01);
    if (n == 1 || dir) cmp8(srx_q[0], tx);
    if (n == 1 || !dir) cmp8(seen, slave_tx.data);
  endtask
  initial begin
    int m;
    {rst_b, tb_sclk, tx_valid, fault_clear, fault_detect_en, slow, open_drain_option, slave_ready} = '0;
    {master_en, ready_en, sel_in_n} = 3'h7;
    {tb_o, tb_oe, slave_index, half_period, reply} = '0;
    tx_req = '0;
    slave_tx = '0;
    lane_mode = LANE_SINGLE;
    seed = 32'hf53a;
    fails = 0;
    n_compared = 0;
    repeat (3) @(negedge core_clk);
    cmp1(sclk_o, 1'b0);
    cmp8({4'h0, slave_select_out_n}, 8'h0f);
    @(negedge core_clk);
    rst_b = 1'b1;
    for (m = 0; m < 16; m++) begin
      lane_mode = lane_mode_t'(m[3:2]);
      open_drain_option = m[1];
      slave_index = 2'(m + (m >> 2));
      half_period = 8'(m % 4);
      mword(m[0], 0);
    end
    // a slow device holds the next word back
    slow = 1'b1;
    mword(1'b0, 0);
    repeat (4) @(negedge core_clk);
    mword(1'b1, 30);
    slow = 1'b0;
    // a foreign master on the select input
    fault_detect_en = 1'b1;
    sel_in_n = 1'b0;
    repeat (6) @(negedge core_clk);
    cmp1(mode_fault, 1'b1);
    cmp1(tx_ready, 1'b0);
    sel_in_n = 1'b1;
    repeat (4) @(negedge core_clk);
    fault_clear = 1'b1;
    @(negedge core_clk);
    fault_clear = 1'b0;
    cmp1(mode_fault, 1'b0);
    fault_detect_en = 1'b0;
    sel_in_n = 1'b0;
    repeat (6) @(negedge core_clk);
    cmp1(mode_fault, 1'b0);
    sel_in_n = 1'b1;
    repeat (4) @(negedge core_clk);
    mword(1'b1, 0);
    // slave role, every lane code and both directions
    master_en = 1'b0;
    for (m = 0; m < 8; m++) begin
      lane_mode = lane_mode_t'(m[2:1]);
      open_drain_option = m[1];
      ready_en = m[1] ^ m[0];
      sword(m[0]);
    end
    // clock with no select: nothing may be taken
    srx_q.delete();
    repeat (8) begin
      #40 tb_sclk = 1'b1;
      #40 tb_sclk = 1'b0;
    end
    #60 cmp8(8'(srx_q.size()), 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
